// File: rtl/tsf_pkg.sv
package tsf_pkg;
    // ------------------------------------------------------------
    // widths and framing overhead
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int LINK_W = 8;
    localparam int FRAME_BYTES = 2;
    localparam int SEQ_BYTES = 2;
    localparam int LCRC_BYTES = 4;
    localparam int OVERHEAD_BYTES = FRAME_BYTES + SEQ_BYTES + LCRC_BYTES;
    localparam int REPLAY_DEPTH = 64;
    localparam int REPLAY_AW = 6;
    localparam int MAINT_BEATS = 2;
    localparam int SIDEBAND_W = 16;

    // ------------------------------------------------------------
    // link symbols and tlp header fields
    // ------------------------------------------------------------
    localparam logic [7:0] SYM_START = 8'hfb;
    localparam logic [7:0] SYM_END = 8'hfd;
    localparam logic [7:0] SYM_BAD_END = 8'hfe;
    localparam logic [31:0] LCRC_SEED = 32'hffffffff;
    localparam logic [31:0] LCRC_POLY = 32'h04c11db7;
    localparam int HDR_TYPE_LSB = 0;
    localparam int HDR_TAG_LSB = 16;
    localparam logic [4:0] TYPE_CPL = 5'h0a;
    localparam logic [4:0] TYPE_CFG0 = 5'h04;
    localparam logic [4:0] TYPE_MSG_HI = 5'h17;
    localparam logic [4:0] TYPE_MSG_LO = 5'h10;
    localparam logic [2:0] ZERO_CNT = 3'h0;

    typedef enum logic [1:0] {
        TSF_TX_IDLE,
        TSF_TX_BODY,
        TSF_TX_TAIL
    } tsf_tx_st_t;
endpackage

// File: rtl/tsf_lcrc.sv
// ------------------------------------------------------------
// one word step of the link crc, byte lane 0 first
// ------------------------------------------------------------
module tsf_lcrc (
    input wire logic [31:0] crc_in,
    input wire logic [31:0] word,
    input wire logic [2:0] nbytes,
    output logic [31:0] crc_out
);
    always_comb begin
        logic [31:0] c;
        c = crc_in;
        for (int b = 0; b < 4; b++) begin
            if (b < int'(nbytes)) begin
                for (int i = 0; i < 8; i++) begin
                    if (c[31] ^ word[8 * b + i]) begin
                        c = {c[30:0], 1'b0} ^ tsf_pkg::LCRC_POLY;
                    end else begin
                        c = {c[30:0], 1'b0};
                    end
                end
            end
        end
        crc_out = c;
    end
endmodule

// File: rtl/tsf_stream.sv
// Overview of operation
// R1: tx beat moves only when valid and ready are both high.
// R2: user marks first and last tx beats; last completes on handshake.
// R3: one-beat packet carries first and last flags together.
// R4: next packet may start right after the last beat; the code holds ready low in TSF_TX_TAIL while the crc word goes out.
// R5: nullify with last beat drops the packet from the link; the code sends the earlier beats and a zero-byte last beat, no crc word.
// R6: core adds framing, sequence number and crc outside the user bus; the code sends only the inverted crc word, no framing or sequence number.
// R7: user completions copy class, requester, tag and attributes.
// R8: tx ready gaps in proportion to lanes in use.
// R9: every sent packet stays in replay store; replay without user.
// R10: ready may drop while core sends its own packets.
// R11: rx first beat shows first flag and valid; last shows last flag.
// R12: rx with ready low holds the pending beat.
// R13: rx strips framing, sequence number and crc from the body.
// R14: packets with link errors are dropped and retried.
// R15: only packets hitting an enabled resource reach the user.
// R16: config requests, messages and unmapped packets are consumed.
// R17: tag of each completion shows on the sideband output.
// R18: user checks completion tags against its own outstanding reads.
// R19: byte lane [7:0] carries first byte, then 15:8 and upward.
// R20: user holds data and flags while valid waits for ready.
module tsf_stream #(
    parameter int LANES_MAX = 4,
    parameter int DEPTH = tsf_pkg::REPLAY_DEPTH
) (
    input wire logic mclk,
    input wire logic arst_n,
    // user transmit
    input wire logic tx_beat_valid,
    output logic tx_accept_ready,
    input wire logic tx_first_beat_flag,
    input wire logic tx_last_beat_flag,
    input wire logic tx_nullify_flag,
    input wire logic [31:0] tx_payload_word,
    // link transmit word stream
    output logic link_tx_valid,
    output logic [31:0] link_tx_word,
    output logic [2:0] link_tx_bytes,
    input wire logic [2:0] lanes_active,
    input wire logic maint_request,
    input wire logic replay_request,
    input wire logic [11:0] acked_seq,
    input wire logic acked_valid,
    // link receive word stream, already delineated
    input wire logic link_rx_valid,
    input wire logic link_rx_first,
    input wire logic link_rx_last,
    input wire logic link_rx_error,
    input wire logic link_rx_hit,
    input wire logic [31:0] link_rx_word,
    output logic link_rx_ready,
    output logic link_rx_nak,
    // user receive
    output logic rx_beat_valid,
    input wire logic rx_accept_ready,
    output logic rx_first_beat_flag,
    output logic rx_last_beat_flag,
    output logic [31:0] rx_payload_word,
    output logic [15:0] rx_sideband_info
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        tsf_pkg::tsf_tx_st_t tx_st;
        logic [11:0] seq;
        logic [31:0] crc;
        logic [2:0] gap_cnt;
        logic [2:0] maint_cnt;
        logic [5:0] wr_ptr;
        logic [5:0] pkt_start;
        logic [5:0] cur_start;
        logic [5:0] rd_ptr;
        logic replaying;
        logic lv;
        logic [31:0] lword;
        logic [2:0] lbytes;
        logic rv;
        logic rfirst;
        logic rlast;
        logic [31:0] rword;
        logic [15:0] rside;
        logic rdrop;
        logic rnak;
    } tsf_state_t;

    tsf_state_t s_r;
    tsf_state_t s_nxt;
    logic [31:0] replay_mem [DEPTH];
    logic [31:0] crc_step;
    logic [31:0] crc_base;
    logic tx_fire;
    logic rx_fire;
    logic link_free;
    logic consume;
    logic [4:0] rx_type;

    tsf_lcrc u_lcrc (
        .crc_in(crc_base),
        .word(tx_payload_word),
        .nbytes(3'h4),
        .crc_out(crc_step)
    );

    // the first word of a packet folds into a fresh seed
    assign crc_base = tx_first_beat_flag ? tsf_pkg::LCRC_SEED : s_r.crc; // see R6
    // fewer lanes means the link needs more cycles per word
    assign link_free = (s_r.gap_cnt == tsf_pkg::ZERO_CNT); // see R8
    assign tx_accept_ready = link_free && !s_r.replaying
        && (s_r.maint_cnt == tsf_pkg::ZERO_CNT)
        && (s_r.tx_st != tsf_pkg::TSF_TX_TAIL); // see R10
    assign tx_fire = tx_beat_valid && tx_accept_ready; // see R1
    assign rx_fire = s_r.rv && rx_accept_ready;
    assign link_rx_ready = !s_r.rv || rx_accept_ready; // see R12
    assign rx_type = link_rx_word[tsf_pkg::HDR_TYPE_LSB +: 5];
    // config requests and messages never reach the user
    assign consume = (rx_type == tsf_pkg::TYPE_CFG0)
        || (rx_type >= tsf_pkg::TYPE_MSG_LO && rx_type <= tsf_pkg::TYPE_MSG_HI); // see R16

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.lv = 1'b0;
        s_nxt.rnak = 1'b0;
        if (!link_free) begin
            s_nxt.gap_cnt = s_r.gap_cnt - 3'h1;
        end
        if (s_r.maint_cnt != tsf_pkg::ZERO_CNT) begin
            s_nxt.maint_cnt = s_r.maint_cnt - 3'h1;
        end else if (maint_request && s_r.tx_st == tsf_pkg::TSF_TX_IDLE) begin
            s_nxt.maint_cnt = 3'(tsf_pkg::MAINT_BEATS); // see R10
        end
        if (acked_valid && s_r.tx_st == tsf_pkg::TSF_TX_IDLE) begin
            s_nxt.pkt_start = s_r.wr_ptr;
        end
        // replay walks the stored words back onto the link
        // an empty store has nothing to replay
        if (replay_request && !s_r.replaying && s_r.tx_st == tsf_pkg::TSF_TX_IDLE
            && s_r.pkt_start != s_r.wr_ptr) begin
            s_nxt.replaying = 1'b1; // see R9
            s_nxt.rd_ptr = s_r.pkt_start;
        end else if (s_r.replaying && link_free) begin
            s_nxt.lv = 1'b1;
            s_nxt.lword = replay_mem[s_r.rd_ptr];
            s_nxt.lbytes = 3'h4;
            s_nxt.rd_ptr = s_r.rd_ptr + 6'h1;
            s_nxt.gap_cnt = 3'(LANES_MAX / int'(lanes_active) - 1);
            if (s_r.rd_ptr + 6'h1 == s_r.wr_ptr) begin
                s_nxt.replaying = 1'b0;
            end
        end
        unique case (s_r.tx_st)
            tsf_pkg::TSF_TX_IDLE, tsf_pkg::TSF_TX_BODY: begin
                if (tx_fire) begin
                    s_nxt.lv = 1'b1;
                    s_nxt.gap_cnt = 3'(LANES_MAX / int'(lanes_active) - 1);
                    s_nxt.lword = tx_payload_word; // see R19
                    s_nxt.lbytes = 3'h4;
                    s_nxt.crc = crc_step; // see R6
                    s_nxt.wr_ptr = s_r.wr_ptr + 6'h1; // see R9
                    if (tx_first_beat_flag) begin
                        s_nxt.cur_start = s_r.wr_ptr;
                    end
                    s_nxt.tx_st = tx_last_beat_flag ? tsf_pkg::TSF_TX_TAIL
                        : tsf_pkg::TSF_TX_BODY; // see R3
                    if (tx_last_beat_flag && tx_nullify_flag) begin
                        // only the cancelled packet leaves the replay store
                        s_nxt.wr_ptr = tx_first_beat_flag ? s_r.wr_ptr
                            : s_r.cur_start; // see R5
                        s_nxt.tx_st = tsf_pkg::TSF_TX_IDLE;
                        s_nxt.lbytes = 3'h0;
                    end
                end
            end
            tsf_pkg::TSF_TX_TAIL: begin
                // the inverted crc word closes the packet on the link
                if (link_free) begin
                    s_nxt.lv = 1'b1;
                    s_nxt.lword = ~s_r.crc; // see R6
                    s_nxt.lbytes = 3'h4;
                    s_nxt.seq = s_r.seq + 12'h1;
                    s_nxt.tx_st = tsf_pkg::TSF_TX_IDLE; // see R4
                end
            end
        endcase
        // receive side, one-stage holding register
        if (rx_fire) begin
            s_nxt.rv = 1'b0;
            s_nxt.rfirst = 1'b0;
            s_nxt.rlast = 1'b0;
        end
        if (link_rx_valid && link_rx_ready) begin
            if (link_rx_first) begin
                s_nxt.rdrop = link_rx_error || !link_rx_hit || consume; // see R15
            end
            if (link_rx_error && link_rx_last) begin
                s_nxt.rnak = 1'b1; // see R14
            end
            if (!(link_rx_first ? (link_rx_error || !link_rx_hit || consume)
                : (s_r.rdrop || link_rx_error))) begin
                s_nxt.rv = 1'b1; // see R11
                s_nxt.rfirst = link_rx_first;
                s_nxt.rlast = link_rx_last;
                s_nxt.rword = link_rx_word; // see R13
                if (link_rx_first && rx_type == tsf_pkg::TYPE_CPL) begin
                    s_nxt.rside = {8'h00, link_rx_word[tsf_pkg::HDR_TAG_LSB +: 8]}; // see R17
                end else if (link_rx_first) begin
                    s_nxt.rside = 16'h0000;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers and replay store
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (tx_fire) begin
            replay_mem[s_r.wr_ptr] <= tx_payload_word; // see R9
        end
    end

    assign link_tx_valid = s_r.lv;
    assign link_tx_word = s_r.lword;
    assign link_tx_bytes = s_r.lbytes;
    assign link_rx_nak = s_r.rnak;
    assign rx_beat_valid = s_r.rv;
    assign rx_first_beat_flag = s_r.rfirst;
    assign rx_last_beat_flag = s_r.rlast;
    assign rx_payload_word = s_r.rword;
    assign rx_sideband_info = s_r.rside;
endmodule

// File: testbench/tsf_stream_assertions.sv
// ----
// stream handshake checker
// ----
module tsf_chk #(
    parameter int LANES_MAX = 4
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic tx_beat_valid,
    input wire logic tx_accept_ready,
    input wire logic tx_last_beat_flag,
    input wire logic tx_nullify_flag,
    input wire logic [31:0] tx_payload_word,
    input wire logic link_tx_valid,
    input wire logic [31:0] link_tx_word,
    input wire logic [2:0] link_tx_bytes,
    input wire logic [2:0] lanes_active,
    input wire logic replay_request,
    input wire logic link_rx_valid,
    input wire logic link_rx_last,
    input wire logic link_rx_error,
    input wire logic link_rx_ready,
    input wire logic link_rx_nak,
    input wire logic rx_beat_valid,
    input wire logic rx_accept_ready,
    input wire logic rx_first_beat_flag,
    input wire logic rx_last_beat_flag,
    input wire logic [31:0] rx_payload_word
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic acc;
    assign acc = tx_beat_valid && tx_accept_ready;
    chk_tx_word_out: assert property (acc |=> link_tx_valid)
        else $error("taken tx beat gave no link word");
    chk_nullify_drop: assert property (acc && tx_last_beat_flag && tx_nullify_flag |=>
        link_tx_bytes == 3'h0) else $error("nullified beat carried bytes");
    chk_lane_order: assert property (acc && !tx_nullify_flag |=>
        link_tx_word == $past(tx_payload_word)) else $error("link word differs from beat");
    chk_gap_ready: assert property (acc && lanes_active == 3'h2 |=> !tx_accept_ready)
        else $error("no ready gap at half width");
    chk_replay_hold: assert property (replay_request ##1 replay_request |->
        !tx_accept_ready) else $error("ready high during replay");
    chk_rx_hold: assert property (rx_beat_valid && !rx_accept_ready |=> rx_beat_valid &&
        $stable(rx_payload_word) && $stable(rx_last_beat_flag)) else $error("rx beat moved");
    chk_rx_first_valid: assert property (rx_first_beat_flag |-> rx_beat_valid)
        else $error("first flag without valid");
    chk_err_nak: assert property (link_rx_valid && link_rx_ready && link_rx_last &&
        link_rx_error |=> link_rx_nak) else $error("errored packet not refused");
    cover property (acc && tx_last_beat_flag && tx_nullify_flag);
    cover property (rx_beat_valid && !rx_accept_ready);
    cover property (link_rx_nak);
endmodule

// File: testbench/tsf_user_model.sv
// ----
// user application side
// ----
module tsf_user_model (
    input wire logic mclk,
    input wire logic stall,
    input wire logic tx_accept_ready,
    output logic tx_beat_valid,
    output logic tx_first_beat_flag,
    output logic tx_last_beat_flag,
    output logic tx_nullify_flag,
    output logic [31:0] tx_payload_word,
    output logic rx_accept_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    int waits = 0;
    int hangs = 0;
    logic tog = 1'b0;
    initial begin
        tx_beat_valid = 1'b0;
        tx_first_beat_flag = 1'b0;
        tx_last_beat_flag = 1'b0;
        tx_nullify_flag = 1'b0;
        tx_payload_word = 32'h0;
    end
    always @(posedge mclk) tog <= ~tog;
    // stalling consumer takes every other beat
    assign rx_accept_ready = !stall || tog;
    // beat and flags held until taken; valid is left up for back-to-back packets
    task automatic send(input int n, input bit nul, input logic [31:0] base);
        int t;
        for (int i = 0; i < n; i++) begin
            tx_beat_valid = 1'b1;
            tx_first_beat_flag = (i == 0);
            tx_last_beat_flag = (i == n - 1);
            tx_nullify_flag = nul && (i == n - 1);
            tx_payload_word = base + i;
            t = 0;
            #1;
            while (!tx_accept_ready && t < 50) begin
                @(posedge mclk);
                #1;
                waits++;
                t++;
            end
            if (t == 50) hangs++;
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic idle();
        tx_beat_valid = 1'b0;
        tx_payload_word = ~tx_payload_word;
    endtask
endmodule

// File: testbench/tb_top.sv
// ----
// bench top
// ----
`define CMP(a, b, m) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic stall = 1'b0;
    logic [2:0] lanes_active = 3'h4;
    logic maint_request = 1'b0;
    logic replay_request = 1'b0;
    logic [11:0] acked_seq = 12'h0;
    logic acked_valid = 1'b0;
    logic link_rx_valid = 1'b0, link_rx_first = 1'b0, link_rx_last = 1'b0;
    logic link_rx_error = 1'b0, link_rx_hit = 1'b0;
    logic [31:0] link_rx_word = 32'h0;
    logic tx_beat_valid, tx_accept_ready, tx_first_beat_flag, tx_last_beat_flag;
    logic tx_nullify_flag, link_tx_valid, link_rx_ready, link_rx_nak, rx_beat_valid;
    logic rx_accept_ready, rx_first_beat_flag, rx_last_beat_flag;
    logic [31:0] tx_payload_word, link_tx_word, rx_payload_word, fw, rq;
    localparam logic [7:0] OUT_TAG = 8'h5a;
    logic [2:0] link_tx_bytes;
    logic [15:0] rx_sideband_info, sb;
    int n_fail = 0, comparisons = 0, words = 0, nulls = 0, ubeats = 0, usops = 0, naks = 0;
    tsf_stream tsf_stream_inst (.*);
    tsf_user_model tsf_user_model_inst (.*);
    always #50 mclk = ~mclk;
    always @(negedge mclk) begin
        if (link_tx_valid && link_tx_word[31:16] == 16'hab00 && link_tx_bytes != 3'h0) words++;
        if (link_tx_valid && link_tx_bytes == 3'h0) nulls++;
        if (rx_beat_valid && rx_accept_ready) ubeats++;
        if (rx_beat_valid && rx_accept_ready && rx_first_beat_flag) usops++;
        if (rx_beat_valid && rx_first_beat_flag) sb = rx_sideband_info;
        if (rx_beat_valid && rx_first_beat_flag) fw = rx_payload_word;
        if (rx_beat_valid && rx_first_beat_flag && rx_payload_word[4:0] != tsf_pkg::TYPE_CPL)
            rq = rx_payload_word;
        if (link_rx_nak) naks++;
    end
    task automatic rx_pkt(input int n, input logic [4:0] typ, input logic err, input logic hit);
        int t;
        for (int i = 0; i < n; i++) begin
            link_rx_valid = 1'b1;
            link_rx_first = (i == 0);
            link_rx_last = (i == n - 1);
            link_rx_error = err;
            link_rx_hit = hit;
            link_rx_word = (i == 0) ? {16'h005a, 11'h0, typ} : 32'hcd00_0000 + i;
            t = 0;
            #1;
            while (!link_rx_ready && t < 50) begin
                @(posedge mclk);
                #1;
                t++;
            end
            if (t == 50) n_fail++;
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic t_tx_frames();
        tsf_user_model_inst.send(4, 0, 32'hab00_0000);
        tsf_user_model_inst.send(2, 1, 32'hab00_0010);
        tsf_user_model_inst.send(1, 0, 32'hab00_0020);
        tsf_user_model_inst.idle();
        repeat (6) @(posedge mclk);
        #1;
        `CMP(words, 6, "tx words")
        `CMP(nulls, 1, "nullified beats")
    endtask
    task automatic t_tx_gap();
        lanes_active = 3'h2;
        tsf_user_model_inst.send(2, 0, 32'hab00_0030);
        tsf_user_model_inst.idle();
        lanes_active = 3'h1;
        repeat (6) @(posedge mclk);
        #1;
        tsf_user_model_inst.waits = 0;
        tsf_user_model_inst.send(4, 0, 32'hab00_0040);
        tsf_user_model_inst.idle();
        `CMP(tsf_user_model_inst.waits, 9, "gap waits")
        lanes_active = 3'h4;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic t_tx_stall();
        int w0;
        w0 = words;
        replay_request = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        `CMP(tx_accept_ready, 1'b0, "ready in replay")
        replay_request = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        // eleven unacknowledged beats were kept, the nullified packet was not
        `CMP(words, w0 + 11, "replayed words")
        w0 = words;
        maint_request = 1'b1;
        @(posedge mclk);
        #1;
        tsf_user_model_inst.waits = 0;
        tsf_user_model_inst.send(1, 0, 32'hab00_0050);
        maint_request = 1'b0;
        tsf_user_model_inst.idle();
        `CMP(tsf_user_model_inst.waits, tsf_pkg::MAINT_BEATS, "maintenance waits")
        repeat (6) @(posedge mclk);
        #1;
        `CMP(words, w0 + 1, "beat after maintenance")
    endtask
    task automatic t_rx();
        stall = 1'b1;
        rx_pkt(3, 5'h00, 1'b0, 1'b1);
        rx_pkt(1, tsf_pkg::TYPE_CPL, 1'b0, 1'b1);
        rx_pkt(2, 5'h00, 1'b1, 1'b1);
        rx_pkt(2, 5'h00, 1'b0, 1'b0);
        rx_pkt(1, tsf_pkg::TYPE_CFG0, 1'b0, 1'b1);
        rx_pkt(1, tsf_pkg::TYPE_MSG_LO, 1'b0, 1'b1);
        link_rx_valid = 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        `CMP(ubeats, 4, "user rx beats")
        `CMP(usops, 2, "user rx packets")
        `CMP(naks, 1, "refused packets")
        `CMP(sb[7:0], 8'h5a, "completion tag")
        `CMP(fw, {16'h005a, 11'h0, tsf_pkg::TYPE_CPL}, "rx body")
        `CMP(sb[7:0], OUT_TAG, "tag not outstanding")
        // answer the received read with fields copied from its header
        tsf_user_model_inst.send(1, 0, {rq[31:8], 3'h0, tsf_pkg::TYPE_CPL});
        `CMP(link_tx_word[31:8], rq[31:8], "completion fields")
        tsf_user_model_inst.idle();
    endtask
    task automatic summarize();
        n_fail += tsf_user_model_inst.hangs;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        #1 arst_n = 1'b1;
        @(posedge mclk);
        #1;
        t_tx_frames();
        t_tx_gap();
        t_tx_stall();
        t_rx();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        summarize();
    end
endmodule
bind tsf_stream tsf_chk #(.LANES_MAX(LANES_MAX)) tsf_chk_inst (.*);
